// ### logic/pfs_port_a_pin_function_select.sv
// Port A pin function select: registers, sync and five pin cells
//
// Operation
// RL1: Reserved bits always read back zero
// RL2: Software writes zero to reserved bits
// RL3: Software uses only listed mode codes
// RL4: Pin 2: port, serial0 clock, interrupt 0
// RL5: Pin 1: port, serial0 transmit, disable 1
// RL6: Pin 0: port, serial0 receive, disable 0
// RL7: Pin 9: port, timer D, serial2 tx, disable 8
// RL8: Debugger attached forces pin 9 debug out
// RL9: Pin 8: port, timer C, serial2 receive
// RL10: Debugger attached forces pin 8 debug in
// RL11: Fourth register entirely reserved, reads zero
// RL12: All mode fields reset to port
// RL13: New routing after write, glitch free
//
// Pads change two edges after a mode write
// Peripherals see a pad level three edges late
// Prohibited codes behave as port; idle inputs read 0
// Mode fields stay writable while the debugger holds pins
`timescale 1ns/1ps

module pfs_port_a_pin_function_select (
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	// Pads, index order pin 0, 1, 2, 8, 9
	input wire logic [4:0] pad_in_i,
	output logic [4:0] pad_out_o,
	output logic [4:0] pad_oe_o,
	// General-purpose port side
	input wire logic [4:0] port_out_i,
	input wire logic [4:0] port_oe_i,
	output logic [4:0] port_in_o,
	// Debugger strap from a pin
	input wire logic debugger_attached_n_i,
	input wire logic debug_tdo_i,
	output logic debug_tdi_o,
	// Serial channel 0
	input wire logic serial0_clock_out_i,
	input wire logic serial0_clock_oe_i,
	output logic serial0_clock_in_o,
	input wire logic serial0_tx_i,
	output logic serial0_rx_o,
	// Serial channel 2
	input wire logic serial2_tx_i,
	output logic serial2_rx_o,
	// Interrupt, timer and output-disable inputs
	output logic ext_interrupt0_o,
	output logic timer_ext_clock_c_o,
	output logic timer_ext_clock_d_o,
	output logic out_disable_req0_o,
	output logic out_disable_req1_o,
	output logic out_disable_req8_o
);

	localparam int NP = pfs_pkg::NUM_PINS;
	localparam int MW = pfs_pkg::MODE_W;
	// Pins 8 and 9 sit above the three pins of the first register
	localparam int L3_BASE = pfs_pkg::PIN8_IX;

	// One flop set per register, so each has a single writer
	logic [2:0][MW-1:0] low1_mode_ff;
	logic [1:0][MW-1:0] low3_mode_ff;
	logic [NP-1:0][MW-1:0] mode_vec;
	logic wr_low1;
	logic wr_low3;
	logic [15:0] rdata_ff;
	logic [NP-1:0] pad_sync;
	logic dbg_att_n_sync;
	logic force_dbg;
	logic [NP-1:0][2:0] fn_out;
	logic [NP-1:0][2:0] fn_oe;
	logic [NP-1:0][2:0] fn_in;
	logic [NP-1:0] dbg_out;
	logic [NP-1:0] dbg_oe;
	logic [NP-1:0] dbg_in;
	logic [NP-1:0] force_vec;

	// ==========================================================
	// Read-back assembly
	// Unimplemented and reserved positions stay zero by construction
	function automatic logic [15:0] read_reg(
		input logic [3:0] addr,
		input logic [NP-1:0][MW-1:0] mode
	);
		logic [15:0] val;
		val = 16'h0000;
		unique case (addr)
			pfs_pkg::OFS_LOW1: begin
				val[pfs_pkg::PIN0_LSB +: MW] = mode[pfs_pkg::PIN0_IX];
				val[pfs_pkg::PIN1_LSB +: MW] = mode[pfs_pkg::PIN1_IX];
				val[pfs_pkg::PIN2_LSB +: MW] = mode[pfs_pkg::PIN2_IX];
			end
			pfs_pkg::OFS_LOW3: begin
				val[pfs_pkg::PIN8_LSB +: MW] = mode[pfs_pkg::PIN8_IX];
				val[pfs_pkg::PIN9_LSB +: MW] = mode[pfs_pkg::PIN9_IX];
			end
			pfs_pkg::OFS_LOW4: begin
				val = pfs_pkg::LOW4_RST;
			end
			default: begin
				val = 16'h0000;
			end
		endcase
		return val;
	endfunction : read_reg

	// Write decode shared by both mode registers
	function automatic logic write_hit(
		input logic wr,
		input logic [3:0] addr,
		input logic [3:0] ofs
	);
		return wr && (addr == ofs);
	endfunction : write_hit

	assign wr_low1 = write_hit(reg_wr_i, reg_addr_i, pfs_pkg::OFS_LOW1);
	assign wr_low3 = write_hit(reg_wr_i, reg_addr_i, pfs_pkg::OFS_LOW3);
	assign mode_vec = {low3_mode_ff, low1_mode_ff};

	// ==========================================================
	// Mode fields of the first register
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			// RL12 Port after reset
			low1_mode_ff[pfs_pkg::PIN0_IX] <=
				pfs_pkg::LOW1_RST[pfs_pkg::PIN0_LSB +: MW];
			low1_mode_ff[pfs_pkg::PIN1_IX] <=
				pfs_pkg::LOW1_RST[pfs_pkg::PIN1_LSB +: MW];
			low1_mode_ff[pfs_pkg::PIN2_IX] <=
				pfs_pkg::LOW1_RST[pfs_pkg::PIN2_LSB +: MW];
		end else if (wr_low1) begin
			// RL1 Reserved bits not stored
			low1_mode_ff[pfs_pkg::PIN0_IX] <=
				reg_wdata_i[pfs_pkg::PIN0_LSB +: MW];
			low1_mode_ff[pfs_pkg::PIN1_IX] <=
				reg_wdata_i[pfs_pkg::PIN1_LSB +: MW];
			low1_mode_ff[pfs_pkg::PIN2_IX] <=
				reg_wdata_i[pfs_pkg::PIN2_LSB +: MW];
		end
	end

	// ==========================================================
	// Mode fields of the third register
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			// RL12 Port after reset
			low3_mode_ff[pfs_pkg::PIN8_IX - L3_BASE] <=
				pfs_pkg::LOW3_RST[pfs_pkg::PIN8_LSB +: MW];
			low3_mode_ff[pfs_pkg::PIN9_IX - L3_BASE] <=
				pfs_pkg::LOW3_RST[pfs_pkg::PIN9_LSB +: MW];
		end else if (wr_low3) begin
			// RL1 Reserved bits not stored
			low3_mode_ff[pfs_pkg::PIN8_IX - L3_BASE] <=
				reg_wdata_i[pfs_pkg::PIN8_LSB +: MW];
			low3_mode_ff[pfs_pkg::PIN9_IX - L3_BASE] <=
				reg_wdata_i[pfs_pkg::PIN9_LSB +: MW];
		end
	end

	// ==========================================================
	// Read data, valid only in the cycle after the strobe
	// Cleared between reads so stale data never lingers
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rdata_ff <= pfs_pkg::RDATA_RST;
		end else if (reg_rd_i) begin
			// RL11 Fourth register reads zero
			rdata_ff <= read_reg(reg_addr_i, mode_vec);
		end else begin
			rdata_ff <= pfs_pkg::RDATA_RST;
		end
	end

	assign reg_rdata_o = rdata_ff;

	// ==========================================================
	// Input synchronisers
	// Pads and the strap are asynchronous to this clock
	pfs_sync #(
		.W(NP),
		.RST_VAL(5'h00)
	) u_pad_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.async_i(pad_in_i),
		.sync_o(pad_sync)
	);

	// Resets to not attached so pins 8 and 9 start as port
	pfs_sync #(
		.W(1),
		.RST_VAL(1'b1)
	) u_dbg_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.async_i(debugger_attached_n_i),
		.sync_o(dbg_att_n_sync)
	);

	assign force_dbg = ~dbg_att_n_sync;
	assign port_in_o = pad_sync;

	// ==========================================================
	// Slot wiring toward the pads
	always_comb begin
		fn_out = '0;
		fn_oe = '0;
		dbg_out = '0;
		dbg_oe = '0;
		force_vec = '0;
		// RL6 Receive and disable are inputs only
		fn_oe[pfs_pkg::PIN0_IX] = 3'h0;
		// RL5 Transmit drives the pad
		fn_out[pfs_pkg::PIN1_IX][0] = serial0_tx_i;
		fn_oe[pfs_pkg::PIN1_IX][0] = 1'b1;
		// RL4 Serial clock is two-way
		fn_out[pfs_pkg::PIN2_IX][0] = serial0_clock_out_i;
		fn_oe[pfs_pkg::PIN2_IX][0] = serial0_clock_oe_i;
		// RL9 Timer and receive inputs only
		fn_oe[pfs_pkg::PIN8_IX] = 3'h0;
		// RL10 Debug data in overrides pin 8
		force_vec[pfs_pkg::PIN8_IX] = force_dbg;
		dbg_oe[pfs_pkg::PIN8_IX] = 1'b0;
		// RL7 Serial 2 transmit drives the pad
		fn_out[pfs_pkg::PIN9_IX][1] = serial2_tx_i;
		fn_oe[pfs_pkg::PIN9_IX][1] = 1'b1;
		// RL8 Debug data out overrides pin 9
		force_vec[pfs_pkg::PIN9_IX] = force_dbg;
		dbg_out[pfs_pkg::PIN9_IX] = debug_tdo_i;
		dbg_oe[pfs_pkg::PIN9_IX] = 1'b1;
	end

	// ==========================================================
	// Pin cells
	// Each cell registers both directions, so a switch is glitch free
	for (genvar i = 0; i < NP; i++) begin : g_pin
		pfs_pin_cell #(
			.CODE_A(pfs_pkg::SLOT_A_CODES[i]),
			.CODE_B(pfs_pkg::SLOT_B_CODES[i]),
			.CODE_C(pfs_pkg::SLOT_C_CODES[i])
		) u_cell (
			.clock_i(clock_i),
			.rst_n_i(rst_n_i),
			.mode_i(mode_vec[i]),
			.force_dbg_i(force_vec[i]),
			.pad_in_i(pad_sync[i]),
			.port_out_i(port_out_i[i]),
			.port_oe_i(port_oe_i[i]),
			.fn_out_i(fn_out[i]),
			.fn_oe_i(fn_oe[i]),
			.dbg_out_i(dbg_out[i]),
			.dbg_oe_i(dbg_oe[i]),
			.pad_out_o(pad_out_o[i]),
			.pad_oe_o(pad_oe_o[i]),
			.fn_in_o(fn_in[i]),
			.dbg_in_o(dbg_in[i])
		);
	end

	// ==========================================================
	// Peripheral inputs, each a flop inside its cell
	// Slot outputs with no peripheral behind them stay unread
	// RL6 Pin 0 receive and disable 0
	assign serial0_rx_o = fn_in[pfs_pkg::PIN0_IX][0];
	assign out_disable_req0_o = fn_in[pfs_pkg::PIN0_IX][1];
	// RL5 Pin 1 disable 1
	assign out_disable_req1_o = fn_in[pfs_pkg::PIN1_IX][1];
	// RL4 Pin 2 clock in and interrupt 0
	assign serial0_clock_in_o = fn_in[pfs_pkg::PIN2_IX][0];
	assign ext_interrupt0_o = fn_in[pfs_pkg::PIN2_IX][1];
	// RL9 Pin 8 timer C and serial 2 receive
	assign timer_ext_clock_c_o = fn_in[pfs_pkg::PIN8_IX][0];
	assign serial2_rx_o = fn_in[pfs_pkg::PIN8_IX][1];
	// RL10 Pin 8 debug data in
	assign debug_tdi_o = dbg_in[pfs_pkg::PIN8_IX];
	// RL7 Pin 9 timer D and disable 8
	assign timer_ext_clock_d_o = fn_in[pfs_pkg::PIN9_IX][0];
	assign out_disable_req8_o = fn_in[pfs_pkg::PIN9_IX][2];

endmodule : pfs_port_a_pin_function_select

// ### logic/pfs_pkg.sv
// Shared constants, field layout and mode decoding for the port A pin mux
package pfs_pkg;

	// ==========================================================
	// Register bus geometry
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam int MODE_W = 3;
	localparam int NUM_PINS = 5;

	// ==========================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_LOW1 = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_LOW3 = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_LOW4 = 4'h4;

	// ==========================================================
	// Reset values
	localparam logic [DATA_W-1:0] LOW1_RST = 16'h0000;
	localparam logic [DATA_W-1:0] LOW3_RST = 16'h0000;
	localparam logic [DATA_W-1:0] LOW4_RST = 16'h0000;
	localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
	localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;

	// ==========================================================
	// Field positions (low bit of each 3-bit mode field)
	localparam int PIN0_LSB = 0;
	localparam int PIN1_LSB = 4;
	localparam int PIN2_LSB = 8;
	localparam int PIN8_LSB = 0;
	localparam int PIN9_LSB = 4;

	// ==========================================================
	// Pin index within the pad and port vectors
	localparam int PIN0_IX = 0;
	localparam int PIN1_IX = 1;
	localparam int PIN2_IX = 2;
	localparam int PIN8_IX = 3;
	localparam int PIN9_IX = 4;

	// ==========================================================
	// Mode codes
	localparam logic [MODE_W-1:0] MD_PORT = 3'h0;
	localparam logic [MODE_W-1:0] MD_PERIPH_A = 3'h1;
	localparam logic [MODE_W-1:0] MD_IRQ = 3'h3;
	localparam logic [MODE_W-1:0] MD_SERIAL2 = 3'h6;
	localparam logic [MODE_W-1:0] MD_OUT_DISABLE = 3'h7;

	// Per-pin slot codes; MD_PORT in a slot means the slot is unused
	localparam logic [NUM_PINS-1:0][MODE_W-1:0] SLOT_A_CODES = {
		MD_PERIPH_A, MD_PERIPH_A, MD_PERIPH_A, MD_PERIPH_A, MD_PERIPH_A};
	localparam logic [NUM_PINS-1:0][MODE_W-1:0] SLOT_B_CODES = {
		MD_SERIAL2, MD_SERIAL2, MD_IRQ, MD_OUT_DISABLE, MD_OUT_DISABLE};
	localparam logic [NUM_PINS-1:0][MODE_W-1:0] SLOT_C_CODES = {
		MD_OUT_DISABLE, MD_PORT, MD_PORT, MD_PORT, MD_PORT};

	// ==========================================================
	// Function selected on a pin
	typedef enum logic [2:0] {
		PFS_FN_PORT,
		PFS_FN_A,
		PFS_FN_B,
		PFS_FN_C,
		PFS_FN_DEBUG
	} pfs_fn_t;

	// Debug overrides everything; unlisted codes fall back to port
	function automatic pfs_fn_t pfs_decode_fn(
		input logic [MODE_W-1:0] mode,
		input logic [MODE_W-1:0] code_a,
		input logic [MODE_W-1:0] code_b,
		input logic [MODE_W-1:0] code_c,
		input logic force_dbg
	);
		pfs_fn_t fn;
		fn = PFS_FN_PORT;
		if (force_dbg) begin
			fn = PFS_FN_DEBUG;
		end else if (mode == MD_PORT) begin
			fn = PFS_FN_PORT;
		end else if (mode == code_a) begin
			fn = PFS_FN_A;
		end else if (mode == code_b) begin
			fn = PFS_FN_B;
		end else if (mode == code_c) begin
			fn = PFS_FN_C;
		end
		return fn;
	endfunction : pfs_decode_fn

endpackage : pfs_pkg

// ### logic/pfs_sync.sv
// Two-stage synchroniser for pad and strap inputs
`timescale 1ns/1ps

module pfs_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// ==========================================================
	// First stage feeds only the second
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;

endmodule : pfs_sync

// ### logic/pfs_pin_cell.sv
// One pad's function mux with registered pad and peripheral sides
`timescale 1ns/1ps

module pfs_pin_cell #(
	parameter logic [2:0] CODE_A = 3'h1,
	parameter logic [2:0] CODE_B = 3'h7,
	parameter logic [2:0] CODE_C = 3'h0
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [2:0] mode_i,
	input wire logic force_dbg_i,
	input wire logic pad_in_i,
	input wire logic port_out_i,
	input wire logic port_oe_i,
	input wire logic [2:0] fn_out_i,
	input wire logic [2:0] fn_oe_i,
	input wire logic dbg_out_i,
	input wire logic dbg_oe_i,
	output logic pad_out_o,
	output logic pad_oe_o,
	output logic [2:0] fn_in_o,
	output logic dbg_in_o
);

	pfs_pkg::pfs_fn_t sel;
	logic pad_out_ff;
	logic pad_oe_ff;
	logic [2:0] fn_in_ff;
	logic dbg_in_ff;
	logic nxt_pad_out;
	logic nxt_pad_oe;

	// RL13 Decode from held mode
	assign sel = pfs_pkg::pfs_decode_fn(mode_i, CODE_A, CODE_B, CODE_C,
		force_dbg_i);

	// ==========================================================
	// Pad drive
	always_comb begin
		nxt_pad_out = 1'b0;
		nxt_pad_oe = 1'b0;
		unique case (sel)
			pfs_pkg::PFS_FN_PORT: begin
				nxt_pad_out = port_out_i;
				nxt_pad_oe = port_oe_i;
			end
			pfs_pkg::PFS_FN_A: begin
				nxt_pad_out = fn_out_i[0];
				nxt_pad_oe = fn_oe_i[0];
			end
			pfs_pkg::PFS_FN_B: begin
				nxt_pad_out = fn_out_i[1];
				nxt_pad_oe = fn_oe_i[1];
			end
			pfs_pkg::PFS_FN_C: begin
				nxt_pad_out = fn_out_i[2];
				nxt_pad_oe = fn_oe_i[2];
			end
			pfs_pkg::PFS_FN_DEBUG: begin
				nxt_pad_out = dbg_out_i;
				nxt_pad_oe = dbg_oe_i;
			end
		endcase
	end

	// RL13 Registered so no glitch
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			pad_out_ff <= 1'b0;
			pad_oe_ff <= 1'b0;
		end else begin
			pad_out_ff <= nxt_pad_out;
			pad_oe_ff <= nxt_pad_oe;
		end
	end

	// ==========================================================
	// Peripheral inputs; deselected ones sit at zero
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			fn_in_ff <= 3'h0;
			dbg_in_ff <= 1'b0;
		end else begin
			fn_in_ff[0] <= (sel == pfs_pkg::PFS_FN_A) & pad_in_i;
			fn_in_ff[1] <= (sel == pfs_pkg::PFS_FN_B) & pad_in_i;
			fn_in_ff[2] <= (sel == pfs_pkg::PFS_FN_C) & pad_in_i;
			dbg_in_ff <= (sel == pfs_pkg::PFS_FN_DEBUG) & pad_in_i;
		end
	end

	assign pad_out_o = pad_out_ff;
	assign pad_oe_o = pad_oe_ff;
	assign fn_in_o = fn_in_ff;
	assign dbg_in_o = dbg_in_ff;

endmodule : pfs_pin_cell

// ### dv/pfs_pad_model.sv
// Pad-side partner that resolves each pin level
`timescale 1ns/1ps

module pfs_pad_model (
	input logic clock_i,
	input logic [4:0] pad_out_i,
	input logic [4:0] pad_oe_i,
	input logic [4:0] ext_en_i,
	input logic [4:0] ext_val_i,
	output logic [4:0] level_o
);
	logic [4:0] float_ff = 5'h00;
	// Undriven pins wander, so a stale level never passes
	always @(posedge clock_i) begin
		float_ff <= ~float_ff;
	end
	assign level_o = (pad_oe_i & pad_out_i) |
		(~pad_oe_i & ext_en_i & ext_val_i) |
		(~pad_oe_i & ~ext_en_i & float_ff);
endmodule : pfs_pad_model

// ### dv/pfs_chk_assertions.sv
// Port checks for the port A pin mux
`timescale 1ns/1ps

module pfs_chk (
	input logic clock_i,
	input logic rst_n_i,
	input logic [3:0] reg_addr_i,
	input logic [15:0] reg_wdata_i,
	input logic reg_wr_i,
	input logic reg_rd_i,
	input logic [15:0] reg_rdata_o,
	input logic [4:0] pad_in_i,
	input logic [4:0] pad_out_o,
	input logic [4:0] pad_oe_o,
	input logic debugger_attached_n_i,
	input logic debug_tdo_i,
	input logic debug_tdi_o,
	input logic serial0_tx_i,
	input logic serial0_rx_o
);
	// ======
	// Shadows and run counters
	logic [15:0] m1_ff;
	logic [15:0] m3_ff;
	logic [2:0] up_ff;
	logic [2:0] dbg_ff;
	// Pin 3 field is not built, so it reads as reserved
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			m1_ff <= 16'h0000;
		end else if (reg_wr_i && reg_addr_i == pfs_pkg::OFS_LOW1) begin
			m1_ff <= reg_wdata_i & 16'h0777;
		end
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			m3_ff <= 16'h0000;
		end else if (reg_wr_i && reg_addr_i == pfs_pkg::OFS_LOW3) begin
			m3_ff <= reg_wdata_i & 16'h0077;
		end
	end
	// Pad paths need a few cycles to flush after reset
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			up_ff <= 3'h0;
		end else if (up_ff != 3'h7) begin
			up_ff <= up_ff + 3'h1;
		end
	end
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || debugger_attached_n_i) begin
			dbg_ff <= 3'h0;
		end else if (dbg_ff != 3'h7) begin
			dbg_ff <= dbg_ff + 3'h1;
		end
	end
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);
	property p_rd(logic [3:0] a, logic [15:0] v);
		$past(reg_rd_i) && $past(reg_addr_i) == a |-> reg_rdata_o == v;
	endproperty
	// ======
	// Assertions
	// idle read zero
	a_rdata_idle_zero: assert property (!$past(reg_rd_i) |->
		reg_rdata_o == 16'h0000) else $error("read data not zero");
	a_low1_readback: assert property (
		p_rd(pfs_pkg::OFS_LOW1, $past(m1_ff))) else $error("low1 readback");
	a_low3_readback: assert property (
		p_rd(pfs_pkg::OFS_LOW3, $past(m3_ff))) else $error("low3 readback");
	a_low4_zero: assert property (
		p_rd(pfs_pkg::OFS_LOW4, 16'h0000)) else $error("low4 not zero");
	a_rx0_route: assert property (up_ff == 3'h7 |-> serial0_rx_o ==
		($past(m1_ff[2:0]) == 3'h1 && $past(pad_in_i[0], 3)))
		else $error("pin 0 receive routing");
	a_tx1_drive: assert property ($past(m1_ff[6:4]) == 3'h1 |->
		pad_oe_o[1] && pad_out_o[1] == $past(serial0_tx_i))
		else $error("pin 1 transmit drive");
	a_tdo_forced: assert property (dbg_ff >= 3'h5 |-> pad_oe_o[4] &&
		pad_out_o[4] == $past(debug_tdo_i)) else $error("pin 9 not forced");
	a_tdi_forced: assert property (dbg_ff >= 3'h5 |-> !pad_oe_o[3] &&
		debug_tdi_o == $past(pad_in_i[3], 3)) else $error("pin 8 not forced");
	c_rx0_selected: cover property ($past(m1_ff[2:0]) == 3'h1 && serial0_rx_o);
	c_debug_held: cover property (dbg_ff == 3'h7);
	c_low4_read: cover property ($past(reg_rd_i) &&
		$past(reg_addr_i) == pfs_pkg::OFS_LOW4 && reg_rdata_o == 16'h0000);
endmodule : pfs_chk

bind pfs_port_a_pin_function_select pfs_chk u_chk (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
	.pad_oe_o(pad_oe_o), .debugger_attached_n_i(debugger_attached_n_i),
	.debug_tdo_i(debug_tdo_i), .debug_tdi_o(debug_tdi_o),
	.serial0_tx_i(serial0_tx_i), .serial0_rx_o(serial0_rx_o)
);

// ### dv/pfs_port_a_pin_function_select_tb.sv
// Self-checking bench for the port A pin mux
`timescale 1ns/1ps

module pfs_port_a_pin_function_select_tb;
	typedef struct packed {
		logic [15:0] w1;
		logic [15:0] w3;
		logic [8:0] fin;
		logic [4:0] oe;
	} pfs_row_t;
	logic clock_i, rst_n_i, reg_wr_i, reg_rd_i;
	logic [3:0] reg_addr_i;
	logic [15:0] reg_wdata_i, reg_rdata_o;
	logic [4:0] pad_in, pad_out_o, pad_oe_o, port_out_i, port_oe_i, port_in_o;
	logic [4:0] ext_en, ext_val;
	logic strap_n, tdo, tdi, ck_out, ck_oe, ck_in, tx0, rx0, tx2, rx2;
	logic ext_interrupt0, tclk_c, tclk_d, out_disable_req0, out_disable_req1, out_disable_req8;
	logic [8:0] fin;
	int mismatches = 0;
	int cmp_count = 0;
	// Row 3 sets reserved and prohibited bits on purpose
	pfs_row_t rows [5] = '{
		'{16'h0000, 16'h0000, 9'h000, 5'h1F},
		'{16'h0111, 16'h0011, 9'h18A, 5'h06},
		'{16'h0377, 16'h0066, 9'h074, 5'h10},
		'{16'hFFFF, 16'hFFFF, 9'h031, 5'h0C},
		'{16'h0222, 16'h0055, 9'h000, 5'h1F}};
	assign fin = {ck_in, rx0, ext_interrupt0, out_disable_req0, out_disable_req1, tclk_c, rx2, tclk_d, out_disable_req8};

	pfs_port_a_pin_function_select u_dut (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .pad_in_i(pad_in), .pad_out_o(pad_out_o),
		.pad_oe_o(pad_oe_o), .port_out_i(port_out_i), .port_oe_i(port_oe_i),
		.port_in_o(port_in_o), .debugger_attached_n_i(strap_n),
		.debug_tdo_i(tdo), .debug_tdi_o(tdi), .serial0_clock_out_i(ck_out),
		.serial0_clock_oe_i(ck_oe), .serial0_clock_in_o(ck_in),
		.serial0_tx_i(tx0), .serial0_rx_o(rx0), .serial2_tx_i(tx2),
		.serial2_rx_o(rx2), .ext_interrupt0_o(ext_interrupt0),
		.timer_ext_clock_c_o(tclk_c), .timer_ext_clock_d_o(tclk_d),
		.out_disable_req0_o(out_disable_req0), .out_disable_req1_o(out_disable_req1),
		.out_disable_req8_o(out_disable_req8));
	pfs_pad_model u_pad (.clock_i(clock_i), .pad_out_i(pad_out_o),
		.pad_oe_i(pad_oe_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
		.level_o(pad_in));

	// ======
	// Tasks
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One bus cycle; read data are valid when it returns
	task automatic bus(input logic w, input logic r, input logic [3:0] a,
		input logic [15:0] d);
		reg_wr_i <= w;
		reg_rd_i <= r;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clock_i);
		#1;
	endtask : bus
	task automatic rd(input logic [3:0] a, input logic [15:0] e,
		input string nm);
		bus(1'b0, 1'b1, a, 16'h0000);
		chk(nm, e, reg_rdata_o);
	endtask : rd
	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 4'h0, 16'h0000);
	endtask : idle
	task automatic complete_run();
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run

	// ======
	// Stimulus
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	initial begin
		#100000;
		mismatches++;
		complete_run();
	end
	initial begin
		rst_n_i = 1'b0;
		{reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
		{port_out_i, port_oe_i, ext_en, ext_val} = '0;
		{strap_n, tdo, ck_out, ck_oe, tx0, tx2} = 6'h3F;
		repeat (16) @(posedge clock_i);
		#1;
		rst_n_i <= 1'b1;
		{port_out_i, port_oe_i, ext_en, ext_val} <= {4{5'h1F}};
		rd(pfs_pkg::OFS_LOW1, 16'h0000, "low1 reset");
		rd(pfs_pkg::OFS_LOW3, 16'h0000, "low3 reset");
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, 1'b0, pfs_pkg::OFS_LOW1, rows[i].w1);
			bus(1'b1, 1'b0, pfs_pkg::OFS_LOW3, rows[i].w3);
			rd(pfs_pkg::OFS_LOW1, rows[i].w1 & 16'h0777, "low1");
			rd(pfs_pkg::OFS_LOW3, rows[i].w3 & 16'h0077, "low3");
			idle(5);
			chk("fn in", {7'h00, rows[i].fin}, {7'h00, fin});
			chk("pad oe", {11'h000, rows[i].oe}, {11'h000, pad_oe_o});
			chk("pad out", {11'h000, rows[i].oe},
				{11'h000, pad_out_o & rows[i].oe});
		end
		// Reserved register and unmapped address
		bus(1'b1, 1'b0, pfs_pkg::OFS_LOW4, 16'hFFFF);
		bus(1'b1, 1'b0, 4'hA, 16'hFFFF);
		rd(pfs_pkg::OFS_LOW4, 16'h0000, "low4");
		rd(4'hA, 16'h0000, "unmapped");
		rd(pfs_pkg::OFS_LOW1, 16'h0222, "low1 kept");
		// Debugger attached over port modes
		strap_n <= 1'b0;
		idle(6);
		chk("pin9 oe", 16'h0001, {15'h0000, pad_oe_o[4]});
		chk("pin8 oe", 16'h0000, {15'h0000, pad_oe_o[3]});
		chk("tdi", 16'h0001, {15'h0000, tdi});
		tdo <= 1'b0;
		idle(2);
		chk("pin9 out", 16'h0000, {15'h0000, pad_out_o[4]});
		strap_n <= 1'b1;
		// Port mode drive and loopback
		bus(1'b1, 1'b0, pfs_pkg::OFS_LOW1, 16'h0000);
		bus(1'b1, 1'b0, pfs_pkg::OFS_LOW3, 16'h0000);
		port_out_i <= 5'h0A;
		idle(5);
		chk("port pad out", 16'h000A, {11'h000, pad_out_o});
		chk("port in", 16'h000A, {11'h000, port_in_o});
		// Peripheral drive must not fall back to the port side
		bus(1'b1, 1'b0, pfs_pkg::OFS_LOW1, 16'h0111);
		bus(1'b1, 1'b0, pfs_pkg::OFS_LOW3, 16'h0066);
		{ck_out, ck_oe, tx0, tx2} <= 4'h0;
		idle(2);
		chk("periph oe", 16'h0012, {11'h000, pad_oe_o});
		chk("periph out", 16'h0000, {11'h000, pad_out_o});
		// Reset in mid-run
		bus(1'b1, 1'b0, pfs_pkg::OFS_LOW1, 16'h0111);
		rst_n_i <= 1'b0;
		idle(3);
		chk("oe in reset", 16'h0000, {11'h000, pad_oe_o});
		rst_n_i <= 1'b1;
		rd(pfs_pkg::OFS_LOW1, 16'h0000, "low1 rerun");
		complete_run();
	end
endmodule : pfs_port_a_pin_function_select_tb
